/* hw/isrl_pkg.sv */
// Shared constants and types for the bus status and remote-control block
package isrl_pkg;

    // ==========================================================
    // Register map, byte addresses on the plain register port
    localparam logic [7:0] ADR_STB = 8'h00;
    localparam logic [7:0] ADR_SRE = 8'h04;
    localparam logic [7:0] ADR_ESR = 8'h08;
    localparam logic [7:0] ADR_ESE = 8'h0c;
    localparam logic [7:0] ADR_OCOND = 8'h10;
    localparam logic [7:0] ADR_OEVT = 8'h14;
    localparam logic [7:0] ADR_OENA = 8'h18;
    localparam logic [7:0] ADR_CTRL = 8'h1c;
    localparam logic [7:0] ADR_MYADDR = 8'h20;
    localparam logic [7:0] ADR_RXD = 8'h24;
    localparam logic [7:0] ADR_TXD = 8'h28;

    // ==========================================================
    // Field positions and reset values
    localparam int STB_ESB = 5;
    localparam int STB_MSS = 6;
    localparam int STB_OSB = 7;
    localparam int ESR_CME = 5;
    localparam int CTRL_CLS = 0;
    localparam int TXD_LAST = 8;
    localparam int RXD_VALID = 8;
    localparam int RXD_EOI = 9;
    localparam logic [4:0] MYADDR_RST = 5'h0c;
    localparam logic [7:0] ENA_RST = 8'h00;

    // ==========================================================
    // Bus commands, seven bits with the parity bit dropped
    localparam logic [6:0] CMD_GTL = 7'h01;
    localparam logic [6:0] CMD_SDC = 7'h04;
    localparam logic [6:0] CMD_LLO = 7'h11;
    localparam logic [6:0] CMD_DCL = 7'h14;
    localparam logic [6:0] CMD_SPE = 7'h18;
    localparam logic [6:0] CMD_SPD = 7'h19;
    localparam logic [6:0] CMD_UNL = 7'h3f;
    localparam logic [6:0] CMD_UNT = 7'h5f;
    localparam logic [1:0] GRP_LISTEN = 2'b01;
    localparam logic [1:0] GRP_TALK = 2'b10;

    // ==========================================================
    // Message string characters and limits
    localparam logic [7:0] CH_STAR = 8'h2a;
    localparam logic [7:0] CH_QUERY = 8'h3f;
    localparam logic [7:0] CH_SEMI = 8'h3b;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [8:0] MAX_LEN = 9'h0ff;

    // ==========================================================
    // Carriers and state types; every bus line is active low
    typedef struct packed {
        logic atn_n;
        logic ren_n;
        logic ifc_n;
        logic srq_n;
        logic eoi_n;
        logic dav_n;
        logic nrfd_n;
        logic ndac_n;
        logic [7:0] dio_n;
    } isrl_pins_t;

    typedef struct packed {
        logic valid;
        logic [7:0] code;
    } isrl_key_t;

    typedef struct packed {
        logic valid;
        logic common;
        logic query;
    } isrl_cmd_t;

    typedef enum logic [1:0] {
        AH_READY = 2'b01,
        AH_ACCEPT = 2'b10
    } isrl_ah_t;

    typedef enum logic [3:0] {
        SH_IDLE = 4'b0001,
        SH_SETTLE = 4'b0010,
        SH_DAV = 4'b0100,
        SH_END = 4'b1000
    } isrl_sh_t;

endpackage

/* hw/isrl_status_remote.sv */
// Bus remote/local control, message framing and status reporting block
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module isrl_status_remote (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire isrl_pkg::isrl_pins_t i_bus,
    output isrl_pkg::isrl_pins_t o_bus,
    output isrl_pkg::isrl_pins_t o_bus_oe,
    input wire logic i_local_key,
    input wire isrl_pkg::isrl_key_t i_key,
    output isrl_pkg::isrl_key_t o_key,
    output logic o_remote,
    output logic o_lockout,
    input wire logic [7:0] i_std_evt,
    input wire logic [7:0] i_oper_cond,
    output isrl_pkg::isrl_cmd_t o_cmd
);
    import isrl_pkg::*;

    // ==========================================================
    // Pin synchronisers; bus idles high, so reset to ones
    localparam int SYNC_W = $bits(isrl_pins_t) + 1;
    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] s1_q;
    logic [SYNC_W-1:0] s2_q;
    assign raw = {i_local_key, i_bus};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
            always_ff @(posedge i_clk_sys) begin
                if (i_rst) begin
                    s1_q[gi] <= 1'b1;
                    s2_q[gi] <= 1'b1;
                end else begin
                    s1_q[gi] <= raw[gi];
                    s2_q[gi] <= s1_q[gi];
                end
            end
        end
    endgenerate

    isrl_pins_t p;
    logic key_lvl;
    assign p = isrl_pins_t'(s2_q[SYNC_W-2:0]);
    assign key_lvl = s2_q[SYNC_W-1];

    logic atn, ren, ifc, dav, eoi;
    logic [7:0] data;
    logic [6:0] cmd;
    assign atn = ~p.atn_n;
    assign ren = ~p.ren_n;
    assign ifc = ~p.ifc_n;
    assign dav = ~p.dav_n;
    assign eoi = ~p.eoi_n;
    assign data = ~p.dio_n;
    assign cmd = data[6:0];

    // ==========================================================
    // State declarations
    isrl_ah_t ah_q;
    isrl_sh_t sh_q;
    logic lstn_q, talk_q, spoll_q, spoll_sent_q;
    logic remote_q, lockout_q, ren_prev_q, key_prev_q;
    logic [4:0] myaddr_q;
    logic [7:0] esr_q, ese_q, oevt_q, oena_q, sre_q, ocond_prev_q;
    logic [7:0] stb_q;
    logic [8:0] total_q;
    logic [7:0] seg_len_q, first_q, last_q;
    logic qry_pend_q, qry_common_q, cme_q;
    logic [7:0] tx_q;
    logic tx_last_q, tx_full_q;
    logic [9:0] rxd_q;
    logic [7:0] sh_byte_q;
    logic sh_eoi_q;

    // ==========================================================
    // Acceptor side: byte taken on DAV while addressed or under ATN
    logic take, take_cmd, take_data, dev_clr;
    assign take = (ah_q == AH_READY) && dav && !ifc
        && (atn || lstn_q) && (sh_q == SH_IDLE);
    assign take_cmd = take && atn;
    assign take_data = take && !atn && lstn_q;
    // Universal clear, or selective clear when listen-addressed
    assign dev_clr = take_cmd && ((cmd == CMD_DCL)
        || (cmd == CMD_SDC && lstn_q));

    always_ff @(posedge i_clk_sys) begin
        if (i_rst || ifc) begin
            ah_q <= AH_READY;
        end else begin
            unique case (ah_q)
                AH_READY: begin
                    if (take) begin
                        ah_q <= AH_ACCEPT;
                    end
                end
                AH_ACCEPT: begin
                    if (!dav) begin
                        ah_q <= AH_READY;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Addressing and serial poll mode
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || ifc) begin
            lstn_q <= 1'b0;
            talk_q <= 1'b0;
            spoll_q <= 1'b0;
        end else if (take_cmd) begin
            if (cmd == {GRP_LISTEN, myaddr_q}) begin
                lstn_q <= 1'b1;
                talk_q <= 1'b0;
            end else if (cmd == CMD_UNL) begin
                lstn_q <= 1'b0;
            end else if (cmd == {GRP_TALK, myaddr_q}) begin
                talk_q <= 1'b1;
                lstn_q <= 1'b0;
            end else if (cmd[6:5] == GRP_TALK || cmd == CMD_UNT) begin
                talk_q <= 1'b0;
            end
            if (cmd == CMD_SPE) begin
                spoll_q <= 1'b1;
            end else if (cmd == CMD_SPD) begin
                spoll_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Remote, local and lockout
    logic key_press;
    assign key_press = key_lvl && !key_prev_q;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            remote_q <= 1'b0;
            lockout_q <= 1'b0;
            ren_prev_q <= 1'b0;
            key_prev_q <= 1'b1;
        end else begin
            ren_prev_q <= ren;
            key_prev_q <= key_lvl;
            if (!ren && ren_prev_q) begin
                remote_q <= 1'b0;
                lockout_q <= 1'b0;
            end else if (take_cmd && cmd == CMD_GTL && lstn_q) begin
                remote_q <= 1'b0;
            end else if (ren && !ren_prev_q) begin
                remote_q <= 1'b1;
            end else if (key_press && !lockout_q) begin
                remote_q <= !remote_q;
            end
            if (take_cmd && cmd == CMD_LLO) begin
                lockout_q <= 1'b1;
            end
        end
    end

    // Keypad events dropped while remote
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_key <= '0;
            o_remote <= 1'b0;
            o_lockout <= 1'b0;
        end else begin
            o_key <= remote_q ? '0 : i_key;
            o_remote <= remote_q;
            o_lockout <= lockout_q;
        end
    end

    // ==========================================================
    // Message string framing
    logic is_end, is_content, seg_any, seg_common, seg_query;
    logic [7:0] eff_first, eff_last;
    assign is_end = (data == CH_SEMI) || (data == CH_LF) || eoi;
    assign is_content = (data != CH_SEMI) && (data != CH_LF)
        && (data != CH_CR);
    assign eff_first = (seg_len_q == 8'h00) ? data : first_q;
    assign eff_last = is_content ? data : last_q;
    assign seg_any = (seg_len_q != 8'h00) || is_content;
    assign seg_common = eff_first == CH_STAR;
    assign seg_query = eff_last == CH_QUERY;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst || ifc || dev_clr) begin
            total_q <= '0;
            seg_len_q <= '0;
            first_q <= '0;
            last_q <= '0;
            o_cmd <= '0;
            cme_q <= 1'b0;
        end else begin
            o_cmd <= '0;
            cme_q <= 1'b0;
            if (take_data) begin
                // Overlong transfer flagged as a command error
                if (total_q == MAX_LEN) begin
                    cme_q <= 1'b1;
                end else begin
                    total_q <= total_q + 9'h001;
                end
                if (data == CH_LF || eoi) begin
                    total_q <= '0;
                end
                if (is_end) begin
                    seg_len_q <= '0;
                    o_cmd.valid <= seg_any;
                    o_cmd.common <= seg_common;
                    o_cmd.query <= seg_query;
                end else if (is_content) begin
                    if (seg_len_q == 8'h00) begin
                        first_q <= data;
                    end
                    if (seg_len_q != 8'hff) begin
                        seg_len_q <= seg_len_q + 8'h01;
                    end
                    last_q <= data;
                end
            end
        end
    end

    // ==========================================================
    // Pending query and one-byte response holding register
    logic new_query, tx_wr, tx_done;
    assign new_query = take_data && is_end && seg_any && seg_query;
    assign tx_wr = i_wr && i_addr == ADR_TXD;
    assign tx_done = (sh_q == SH_END) && !spoll_q;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst || ifc || dev_clr) begin
            qry_pend_q <= 1'b0;
            qry_common_q <= 1'b0;
            tx_full_q <= 1'b0;
            tx_q <= '0;
            tx_last_q <= 1'b0;
        end else if (new_query) begin
            // A newer query discards any older answer
            qry_pend_q <= 1'b1;
            qry_common_q <= seg_common;
            tx_full_q <= 1'b0;
        end else begin
            if (tx_wr && qry_pend_q) begin
                tx_q <= i_wdata[7:0];
                tx_last_q <= i_wdata[TXD_LAST];
                tx_full_q <= 1'b1;
            end else if (tx_done) begin
                tx_full_q <= 1'b0;
                if (tx_last_q) begin
                    qry_pend_q <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Source handshake: response bytes or one serial poll byte
    logic sh_go;
    assign sh_go = talk_q && !atn && !ifc && ((spoll_q && !spoll_sent_q)
        || (!spoll_q && qry_pend_q && tx_full_q));

    always_ff @(posedge i_clk_sys) begin
        if (i_rst || ifc || dev_clr) begin
            sh_q <= SH_IDLE;
            sh_byte_q <= '0;
            sh_eoi_q <= 1'b0;
            spoll_sent_q <= 1'b0;
        end else begin
            if (!talk_q || !spoll_q) begin
                spoll_sent_q <= 1'b0;
            end
            unique case (sh_q)
                SH_IDLE: begin
                    if (sh_go) begin
                        sh_q <= SH_SETTLE;
                        sh_byte_q <= spoll_q ? stb_q : tx_q;
                        sh_eoi_q <= !spoll_q && tx_last_q;
                    end
                end
                SH_SETTLE: begin
                    if (atn) begin
                        sh_q <= SH_IDLE;
                    end else if (p.nrfd_n) begin
                        sh_q <= SH_DAV;
                    end
                end
                SH_DAV: begin
                    if (p.ndac_n) begin
                        sh_q <= SH_END;
                    end
                end
                SH_END: begin
                    sh_q <= SH_IDLE;
                    if (spoll_q) begin
                        spoll_sent_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Status system
    logic clr_status, esr_rd, oevt_rd, esb, osb, mss;
    logic [7:0] esr_set, stb_sum;
    assign clr_status = i_wr && i_addr == ADR_CTRL && i_wdata[CTRL_CLS];
    assign esr_rd = i_rd && i_addr == ADR_ESR;
    assign oevt_rd = i_rd && i_addr == ADR_OEVT;
    assign esr_set = i_std_evt | (8'(cme_q) << ESR_CME);
    assign esb = |(esr_q & ese_q);
    assign osb = |(oevt_q & oena_q);
    assign stb_sum = (8'(esb) << STB_ESB) | (8'(osb) << STB_OSB);
    assign mss = |(stb_sum & sre_q);

    // Set wins over a same-cycle clear so no event is lost
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            esr_q <= '0;
            oevt_q <= '0;
            ocond_prev_q <= '0;
        end else begin
            ocond_prev_q <= i_oper_cond;
            esr_q <= ((esr_rd || clr_status) ? '0 : esr_q)
                | esr_set;
            oevt_q <= ((oevt_rd || clr_status) ? '0 : oevt_q)
                | (i_oper_cond & ~ocond_prev_q);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            stb_q <= '0;
            o_bus <= '0;
            o_bus_oe <= '0;
        end else begin
            stb_q <= stb_sum | (8'(mss) << STB_MSS);
            o_bus <= '0;
            o_bus.dio_n <= ~sh_byte_q;
            o_bus_oe <= '0;
            o_bus_oe.srq_n <= mss;
            o_bus_oe.nrfd_n <= (ah_q == AH_ACCEPT) && (atn || lstn_q);
            o_bus_oe.ndac_n <= (ah_q == AH_READY) && (atn || lstn_q);
            if (sh_q != SH_IDLE && sh_q != SH_END) begin
                o_bus_oe.dio_n <= 8'hff;
                o_bus_oe.eoi_n <= sh_eoi_q;
            end
            o_bus_oe.dav_n <= (sh_q == SH_DAV);
        end
    end

    // ==========================================================
    // Register port: enables and address written here; TXD is written by the response block
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ese_q <= ENA_RST;
            oena_q <= ENA_RST;
            sre_q <= ENA_RST;
            myaddr_q <= MYADDR_RST;
        end else if (i_wr) begin
            unique case (i_addr)
                ADR_ESE: ese_q <= i_wdata[7:0];
                ADR_OENA: oena_q <= i_wdata[7:0];
                // MSS position is not a summary, so never enabled
                ADR_SRE: sre_q <= i_wdata[7:0] & ~(8'h01 << STB_MSS);
                ADR_MYADDR: myaddr_q <= i_wdata[4:0];
                default: ;
            endcase
        end
    end

    // Last received data byte; a read empties it, a new byte wins
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            rxd_q <= '0;
        end else if (take_data) begin
            rxd_q <= {eoi, 1'b1, data};
        end else if (i_rd && i_addr == ADR_RXD) begin
            rxd_q[RXD_VALID] <= 1'b0;
        end
    end

    logic [15:0] ctrl_rd;
    assign ctrl_rd = {7'h00, qry_common_q, qry_pend_q, tx_full_q,
        spoll_q, talk_q, lstn_q, lockout_q, remote_q, 1'b0};

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            unique case (i_addr)
                ADR_STB: o_rdata <= {8'h00, stb_q};
                ADR_SRE: o_rdata <= {8'h00, sre_q};
                ADR_ESR: o_rdata <= {8'h00, esr_q};
                ADR_ESE: o_rdata <= {8'h00, ese_q};
                ADR_OCOND: o_rdata <= {8'h00, i_oper_cond};
                ADR_OEVT: o_rdata <= {8'h00, oevt_q};
                ADR_OENA: o_rdata <= {8'h00, oena_q};
                ADR_CTRL: o_rdata <= ctrl_rd;
                ADR_MYADDR: o_rdata <= {11'h000, myaddr_q};
                ADR_RXD: o_rdata <= {6'h00, rxd_q};
                ADR_TXD: o_rdata <= {7'h00, tx_last_q, tx_q};
                default: o_rdata <= '0;
            endcase
        end else begin
            o_rdata <= '0;
        end
    end

endmodule
`default_nettype wire

/* tb/isrl_chk.sv */
// Port assertions for the status and remote-control block
`timescale 1ns/1ps
`default_nettype none
module isrl_chk (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic i_rd,
    input wire logic [15:0] o_rdata,
    input wire isrl_pkg::isrl_pins_t i_bus,
    input wire isrl_pkg::isrl_pins_t o_bus_oe,
    input wire isrl_pkg::isrl_key_t i_key,
    input wire isrl_pkg::isrl_key_t o_key,
    input wire logic o_remote,
    input wire logic [7:0] i_std_evt
);
    import isrl_pkg::*;
    logic [1:0] quiet_q;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);
    // ==========================================================
    // Quiet event input, so a read clear cannot race a late set
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || i_std_evt != 8'h00) begin
            quiet_q <= 2'h0;
        end else if (quiet_q != 2'h3) begin
            quiet_q <= quiet_q + 2'h1;
        end
    end
    // ==========================================================
    // Assertions
    rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data not idle");
    sre_six_a: assert property ($past(i_rd) && $past(i_addr) == ADR_SRE
        |-> !o_rdata[STB_MSS]) else $error("SRE bit 6 set");
    esr_clear_a: assert property (
        i_rd && i_addr == ADR_ESR && $past(i_rd) && $past(i_addr) == ADR_ESR
        && quiet_q == 2'h3 && i_std_evt == 8'h00 |=> o_rdata == 16'h0000)
        else $error("event register read did not clear it");
    key_block_a: assert property (
        o_remote && $past(o_remote) |-> o_key == '0)
        else $error("keypad passed while remote");
    key_pass_a: assert property (
        !o_remote && !$past(o_remote) && !$past(i_rst)
        |-> o_key == $past(i_key)) else $error("keypad lost");
    ren_remote_a: assert property (
        $fell(i_bus.ren_n) |-> ##[1:4] o_remote) else $error("no remote");
    ren_local_a: assert property (
        $rose(i_bus.ren_n) |-> ##[1:4] !o_remote) else $error("no local");
    ifc_abort_a: assert property (
        (!i_bus.ifc_n) [*5] |-> !o_bus_oe.dav_n && o_bus_oe.dio_n == 8'h00)
        else $error("transfer survives clear");
    srq_mss_a: assert property (
        $past(i_rd) && $past(i_addr) == ADR_STB && $stable(o_bus_oe.srq_n)
        && $past(o_bus_oe.srq_n, 2) == o_bus_oe.srq_n
        |-> o_rdata[STB_MSS] == o_bus_oe.srq_n) else $error("MSS and SRQ");
endmodule
bind isrl_status_remote isrl_chk isrl_chk_i (
    .i_clk_sys, .i_rst, .i_addr, .i_rd, .o_rdata, .i_bus, .o_bus_oe,
    .i_key, .o_key, .o_remote, .i_std_evt
);
`default_nettype wire

/* tb/isrl_host_model.sv */
// Bus controller model: sends commands and data, accepts replies
`timescale 1ns/1ps
`default_nettype none
module isrl_host_model (
    input wire logic i_clk_sys,
    input wire isrl_pkg::isrl_pins_t i_wire,
    output isrl_pkg::isrl_pins_t o_drv
);
    import isrl_pkg::*;
    initial o_drv = '1;
    task automatic lines(input logic ren, input logic ifc);
        o_drv.ren_n <= !ren;
        o_drv.ifc_n <= !ifc;
    endtask
    // Released lines float to the pull-up level
    task automatic send(input logic [7:0] b, input logic atn,
            output logic ok);
        int n;
        n = 0;
        @(posedge i_clk_sys);
        o_drv.atn_n <= !atn;
        o_drv.dio_n <= ~b;
        o_drv.nrfd_n <= 1'b1;
        o_drv.ndac_n <= 1'b1;
        @(posedge i_clk_sys);
        while ((i_wire.ndac_n || !i_wire.nrfd_n) && n < 60) begin
            @(posedge i_clk_sys);
            n++;
        end
        o_drv.dav_n <= 1'b0;
        @(posedge i_clk_sys);
        while (!i_wire.ndac_n && n < 60) begin
            @(posedge i_clk_sys);
            n++;
        end
        ok = n < 60;
        o_drv.dav_n <= 1'b1;
        o_drv.dio_n <= 8'hff;
        repeat (4) @(posedge i_clk_sys);
    endtask
    // Slow start holds not-ready to stall the talker
    task automatic recv(input int slow, output logic [7:0] b,
            output logic ok);
        int n;
        n = 0;
        @(posedge i_clk_sys);
        o_drv.atn_n <= 1'b1;
        o_drv.nrfd_n <= 1'b0;
        o_drv.ndac_n <= 1'b0;
        repeat (slow + 1) @(posedge i_clk_sys);
        o_drv.nrfd_n <= 1'b1;
        while (i_wire.dav_n && n < 60) begin
            @(posedge i_clk_sys);
            n++;
        end
        b = ~i_wire.dio_n;
        o_drv.ndac_n <= 1'b1;
        while (!i_wire.dav_n && n < 60) begin
            @(posedge i_clk_sys);
            n++;
        end
        ok = n < 60;
        @(posedge i_clk_sys);
    endtask
endmodule
`default_nettype wire

/* tb/isrl_status_remote_test.sv */
// Self-checking bench for the status and remote-control block
`timescale 1ns/1ps
`default_nettype none
module isrl_status_remote_test;
    import isrl_pkg::*;
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [15:0] d;
        logic [7:0] c;
        logic [15:0] e;
    } isrl_row_t;
    logic clk, rst, wr, rd, lkey, remote, lockout, ok;
    logic [7:0] addr, evt, cond, rx;
    logic [15:0] wdata, rdata, q;
    logic [1:0] seen;
    isrl_pins_t bus_w, bus_out, bus_oe, host_drv;
    isrl_key_t key_in, key_out;
    isrl_cmd_t cmd;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    isrl_row_t rows [8] = '{
        '{1'b1, ADR_ESE, 16'h0020, 8'h00, 16'h0020},
        '{1'b1, ADR_OENA, 16'h005a, 8'h00, 16'h005a},
        '{1'b1, ADR_SRE, 16'h00ff, 8'h00, 16'h00bf},
        '{1'b1, ADR_ESR, 16'h00ff, 8'h00, 16'h0000},
        '{1'b1, ADR_STB, 16'h00ff, 8'h00, 16'h0000},
        '{1'b1, ADR_OCOND, 16'h00ff, 8'h3c, 16'h003c},
        '{1'b0, ADR_MYADDR, 16'h0000, 8'h3c, 16'h000c},
        '{1'b1, 8'h40, 16'hffff, 8'h00, 16'h0000}};
    // Open-collector lines: low when any party pulls
    assign bus_w = host_drv & (~bus_oe | bus_out);
    isrl_status_remote isrl_status_remote_i (
        .i_clk_sys(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_bus(bus_w),
        .o_bus(bus_out), .o_bus_oe(bus_oe), .i_local_key(lkey),
        .i_key(key_in), .o_key(key_out), .o_remote(remote),
        .o_lockout(lockout), .i_std_evt(evt), .i_oper_cond(cond),
        .o_cmd(cmd));
    isrl_host_model isrl_host_model_i (
        .i_clk_sys(clk), .i_wire(bus_w), .o_drv(host_drv));
    // ==========================================================
    // Tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a,
            input logic [15:0] d, output logic [15:0] r);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 r = rdata;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        acc(1'b0, a, 16'h0000, q);
        check(q, exp);
    endtask
    task automatic tx(input logic [7:0] b, input logic atn);
        isrl_host_model_i.send(b, atn, ok);
        check({15'h0, ok}, 16'h0001);
    endtask
    task automatic str(input string s);
        foreach (s[i]) tx(s[i], 1'b0);
        tx(CH_LF, 1'b0);
    endtask
    task automatic press;
        lkey <= 1'b1;
        repeat (4) @(posedge clk);
        lkey <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic pulse;
        evt <= 8'h20;
        @(posedge clk);
        evt <= 8'h00;
        repeat (5) @(posedge clk);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (cmd.valid === 1'b1) seen <= {cmd.common, cmd.query};
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict;
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        {rst, wr, rd, lkey, addr, evt, cond, wdata} = {4'h8, 40'h0};
        key_in = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (rows[i]) begin
            cond <= rows[i].c;
            acc(rows[i].w, rows[i].a, rows[i].d, q);
            rdchk(rows[i].a, rows[i].e);
        end
        rdchk(ADR_STB, 16'h00c0);
        check({15'h0, bus_oe.srq_n}, 16'h0001);
        acc(1'b1, ADR_CTRL, 16'h0001, q);
        repeat (2) @(posedge clk);
        rdchk(ADR_OEVT, 16'h0000);
        rdchk(ADR_STB, 16'h0000);
        check({15'h0, bus_oe.srq_n}, 16'h0000);
        pulse;
        pulse;
        rdchk(ADR_STB, 16'h0060);
        rdchk(ADR_ESR, 16'h0020);
        rdchk(ADR_ESR, 16'h0000);
        rdchk(ADR_STB, 16'h0000);
        key_in <= '{1'b1, 8'h31};
        repeat (2) @(posedge clk);
        check({7'h0, key_out}, 16'h0131);
        press;
        check({15'h0, remote}, 16'h0001);
        check({7'h0, key_out}, 16'h0000);
        press;
        check({15'h0, remote}, 16'h0000);
        isrl_host_model_i.lines(1'b1, 1'b0);
        repeat (5) @(posedge clk);
        check({15'h0, remote}, 16'h0001);
        tx({1'b0, CMD_LLO}, 1'b1);
        press;
        check({14'h0, lockout, remote}, 16'h0003);
        tx({1'b0, CMD_UNL}, 1'b1);
        tx({1'b0, CMD_GTL}, 1'b1);
        check({15'h0, remote}, 16'h0001);
        tx({1'b0, GRP_LISTEN, MYADDR_RST}, 1'b1);
        tx({1'b0, CMD_GTL}, 1'b1);
        check({15'h0, remote}, 16'h0000);
        isrl_host_model_i.lines(1'b0, 1'b0);
        repeat (5) @(posedge clk);
        check({15'h0, lockout}, 16'h0000);
        str("*E?");
        check({14'h0, seen}, 16'h0003);
        acc(1'b1, ADR_TXD, 16'h0137, q);
        str("X?");
        check({14'h0, seen}, 16'h0001);
        check({8'h0, bus_oe.dio_n}, 16'h0000);
        acc(1'b1, ADR_TXD, 16'h0142, q);
        tx({1'b0, GRP_TALK, MYADDR_RST}, 1'b1);
        isrl_host_model_i.recv(6, rx, ok);
        check({7'h0, ok, rx}, 16'h0142);
        pulse;
        tx({1'b0, CMD_SPE}, 1'b1);
        tx({1'b0, GRP_TALK, MYADDR_RST}, 1'b1);
        isrl_host_model_i.recv(0, rx, ok);
        check({7'h0, ok, rx}, 16'h0160);
        tx({1'b0, CMD_SPD}, 1'b1);
        acc(1'b0, ADR_CTRL, 16'h0000, q);
        check(q & 16'h0030, 16'h0010);
        isrl_host_model_i.lines(1'b0, 1'b1);
        repeat (6) @(posedge clk);
        isrl_host_model_i.lines(1'b0, 1'b0);
        repeat (4) @(posedge clk);
        acc(1'b0, ADR_CTRL, 16'h0000, q);
        check(q & 16'h0038, 16'h0000);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdchk(ADR_SRE, 16'h0000);
        rdchk(ADR_ESE, 16'h0000);
        give_verdict;
    end
endmodule
`default_nettype wire
